/* File: rtl/nested_vector_irq_ctrl_consts.vh */
// nested_vector_irq_ctrl_consts.vh: register map, field positions and reset values of the interrupt controller
// assumes a word-wide private peripheral bus carrying full 32-bit byte addresses
`ifndef NESTED_VECTOR_IRQ_CTRL_CONSTS_VH
`define NESTED_VECTOR_IRQ_CTRL_CONSTS_VH

`define NESTED_VECTOR_IRQ_CTRL_SET_EN_BASE 32'hE000E100
`define NESTED_VECTOR_IRQ_CTRL_CLR_EN_BASE 32'hE000E180
`define NESTED_VECTOR_IRQ_CTRL_SET_PD_BASE 32'hE000E200
`define NESTED_VECTOR_IRQ_CTRL_CLR_PD_BASE 32'hE000E280
`define NESTED_VECTOR_IRQ_CTRL_ACTIVE_BASE 32'hE000E300
`define NESTED_VECTOR_IRQ_CTRL_PRIO_BASE 32'hE000E400
`define NESTED_VECTOR_IRQ_CTRL_PRIO_LAST 32'hE000E4EF
`define NESTED_VECTOR_IRQ_CTRL_TRIG_ADDR 32'hE000EF00
`define NESTED_VECTOR_IRQ_CTRL_BANK_MASK 32'hFFFFFF80
`define NESTED_VECTOR_IRQ_CTRL_PRIO_MASK 32'hFFFFFF00
`define NESTED_VECTOR_IRQ_CTRL_TRIG_LSB 0
`define NESTED_VECTOR_IRQ_CTRL_TRIG_MSB 8
`define NESTED_VECTOR_IRQ_CTRL_MAX_IRQ 240
`define NESTED_VECTOR_IRQ_CTRL_WORD_ZERO 32'h00000000
`define NESTED_VECTOR_IRQ_CTRL_PRIO_ZERO 8'h00
`define NESTED_VECTOR_IRQ_CTRL_PRIO_IDLE 9'h100

`endif

/* File: rtl/nested_vector_irq_ctrl_core.v */
// nested_vector_irq_ctrl_core.v: interrupt controller register banks, per-line state and arbiter
// assumes a single-cycle private bus (read data next cycle), core entry/return strobes
// assumes peripheral lines are asynchronous and pass two flops before use
// assumes the core gives at most one entry and one return strobe per cycle
`timescale 1ns/1ps
`include "nested_vector_irq_ctrl_consts.vh"

module nested_vector_irq_ctrl_core #(
   parameter NUM_IRQ = 240,
   parameter PRIO_BITS = 4,
   parameter SOFT_TRIGGER_REG_USER_OK = 0
) (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_sel,
   input wire i_wr,
   input wire i_priv,
   input wire [31:0] i_addr,
   input wire [31:0] i_wdata,
   input wire [3:0] i_be,
   output reg [31:0] o_rdata,
   output reg o_bus_err,
   input wire [NUM_IRQ-1:0] i_irq,
   input wire i_nmi,
   input wire [2:0] i_prigroup,
   input wire i_entry,
   input wire [7:0] i_entry_num,
   input wire i_return,
   input wire [7:0] i_return_num,
   output reg o_irq_req,
   output reg [7:0] o_irq_num,
   output reg [7:0] o_irq_prio,
   output reg [7:0] o_irq_group,
   output reg o_nmi
);

   localparam NWORDS = (NUM_IRQ + 31) / 32;
   localparam NPRIO = (NUM_IRQ + 3) / 4;

   reg [NUM_IRQ-1:0] en_r;
   reg [NUM_IRQ-1:0] pend_r;
   reg [NUM_IRQ-1:0] act_r;
   reg [7:0] prio_r [0:NUM_IRQ-1];
   reg [NUM_IRQ-1:0] irq_s1_r;
   reg [NUM_IRQ-1:0] irq_s2_r;
   reg [NUM_IRQ-1:0] irq_d_r;
   reg nmi_s1_r;
   reg [NUM_IRQ-1:0] en_nxt;
   reg [NUM_IRQ-1:0] pend_nxt;
   reg [NUM_IRQ-1:0] act_nxt;
   reg [31:0] rdata_nxt;
   reg err_nxt;

   // byte lane mask, keeps only implemented upper priority bits
   localparam [7:0] PRIO_KEEP = ~((8'h01 << (8 - PRIO_BITS)) - 8'h01);

   function in_bank;
      input [31:0] a;
      input [31:0] base;
      begin
         in_bank = ((a & `NESTED_VECTOR_IRQ_CTRL_BANK_MASK) == base) && (a[6:0] < NWORDS * 4);
      end
   endfunction

   function [7:0] group_of;
      input [7:0] p;
      input [2:0] g;
      begin
         // grouping field g: bits [7:g+1] are group, the rest subpriority
         group_of = p & (8'hFF << ({5'h00, g} + 8'h01));
      end
   endfunction

   wire acc = i_sel;
   wire [31:0] wofs = i_addr - `NESTED_VECTOR_IRQ_CTRL_PRIO_BASE;
   wire a_sen = in_bank(i_addr, `NESTED_VECTOR_IRQ_CTRL_SET_EN_BASE);
   wire a_cen = in_bank(i_addr, `NESTED_VECTOR_IRQ_CTRL_CLR_EN_BASE);
   wire a_spd = in_bank(i_addr, `NESTED_VECTOR_IRQ_CTRL_SET_PD_BASE);
   wire a_cpd = in_bank(i_addr, `NESTED_VECTOR_IRQ_CTRL_CLR_PD_BASE);
   wire a_act = in_bank(i_addr, `NESTED_VECTOR_IRQ_CTRL_ACTIVE_BASE);
   wire a_pri = (i_addr >= `NESTED_VECTOR_IRQ_CTRL_PRIO_BASE) && (i_addr <= `NESTED_VECTOR_IRQ_CTRL_PRIO_LAST)
      && (wofs[31:2] < NPRIO);
   wire a_trg = (i_addr == `NESTED_VECTOR_IRQ_CTRL_TRIG_ADDR);
   wire hit = a_sen | a_cen | a_spd | a_cpd | a_act | a_pri | a_trg;
   // trigger register can be opened to user code; all others need privilege
   wire refuse = acc && hit && !i_priv && !(a_trg && SOFT_TRIGGER_REG_USER_OK != 0);
   wire ok_wr = acc && i_wr && hit && !refuse;
   wire [2:0] widx = i_addr[4:2];
   wire [8:0] trg_num = i_wdata[`NESTED_VECTOR_IRQ_CTRL_TRIG_MSB:`NESTED_VECTOR_IRQ_CTRL_TRIG_LSB];

   integer i;
   integer n_wr;
   integer n_st;
   integer n_rd;
   integer n_ar;

   // one-cycle strike vectors (lvl_w is the held synced level), one bit per line, decoded once for the state logic
   reg [NUM_IRQ-1:0] set_en_w;
   reg [NUM_IRQ-1:0] clr_en_w;
   reg [NUM_IRQ-1:0] set_pd_w;
   reg [NUM_IRQ-1:0] clr_pd_w;
   reg [NUM_IRQ-1:0] trg_w;
   reg [NUM_IRQ-1:0] entry_w;
   reg [NUM_IRQ-1:0] return_w;
   reg [NUM_IRQ-1:0] prio_we;
   reg [NUM_IRQ-1:0] lvl_w;
   reg [NUM_IRQ-1:0] edge_w;

   // line n sits at bit n%32 of bank word n/32
   function bank_bit;
      input [31:0] d;
      input [2:0] w;
      input integer n;
      begin
         bank_bit = (w == n / 32) && d[n % 32];
      end
   endfunction

   // trigger numbers at or above NUM_IRQ strike nothing
   always @*
   begin
      set_en_w = {NUM_IRQ{1'b0}};
      clr_en_w = {NUM_IRQ{1'b0}};
      set_pd_w = {NUM_IRQ{1'b0}};
      clr_pd_w = {NUM_IRQ{1'b0}};
      trg_w = {NUM_IRQ{1'b0}};
      entry_w = {NUM_IRQ{1'b0}};
      return_w = {NUM_IRQ{1'b0}};
      prio_we = {NUM_IRQ{1'b0}};
      lvl_w = {NUM_IRQ{1'b0}};
      edge_w = {NUM_IRQ{1'b0}};
      for (n_wr = 0; n_wr < NUM_IRQ; n_wr = n_wr + 1)
      begin
         set_en_w[n_wr] = ok_wr && a_sen && bank_bit(i_wdata, widx, n_wr);
         clr_en_w[n_wr] = ok_wr && a_cen && bank_bit(i_wdata, widx, n_wr);
         set_pd_w[n_wr] = ok_wr && a_spd && bank_bit(i_wdata, widx, n_wr);
         clr_pd_w[n_wr] = ok_wr && a_cpd && bank_bit(i_wdata, widx, n_wr);
         trg_w[n_wr] = ok_wr && a_trg && (trg_num == n_wr);
         entry_w[n_wr] = i_entry && (i_entry_num == n_wr);
         return_w[n_wr] = i_return && (i_return_num == n_wr);
         prio_we[n_wr] = ok_wr && a_pri && (wofs[31:2] == n_wr / 4) && i_be[n_wr % 4];
         lvl_w[n_wr] = irq_s2_r[n_wr];
         edge_w[n_wr] = irq_s2_r[n_wr] && !irq_d_r[n_wr];
      end
   end

   // synchronisers: first stage read only by the second
   // third flop holds the previous synced level for the edge detector
   always @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         irq_s1_r <= {NUM_IRQ{1'b0}};
         irq_s2_r <= {NUM_IRQ{1'b0}};
         irq_d_r <= {NUM_IRQ{1'b0}};
         nmi_s1_r <= 1'b0;
         o_nmi <= 1'b0;
      end
      else
      begin
         irq_s1_r <= i_irq;
         irq_s2_r <= irq_s1_r;
         irq_d_r <= irq_s2_r;
         nmi_s1_r <= i_nmi;
         o_nmi <= nmi_s1_r;
      end
   end

   always @*
   begin
      en_nxt = en_r;
      pend_nxt = pend_r;
      act_nxt = act_r;
      for (i = 0; i < NUM_IRQ; i = i + 1)
      begin
         // clears first so that hardware and software sets below win
         if (clr_en_w[i])
            en_nxt[i] = 1'b0;
         if (set_en_w[i])
            en_nxt[i] = 1'b1;
         if (clr_pd_w[i])
            pend_nxt[i] = 1'b0;
         if (entry_w[i])
         begin
            pend_nxt[i] = 1'b0;
            act_nxt[i] = 1'b1;
         end
         if (return_w[i])
            act_nxt[i] = 1'b0;
         // level seen while not active, or a fresh rising edge
         if ((lvl_w[i] && !act_nxt[i]) || edge_w[i])
            pend_nxt[i] = 1'b1;
         if (set_pd_w[i])
            pend_nxt[i] = 1'b1;
         if (trg_w[i])
            pend_nxt[i] = 1'b1;
      end
   end

   always @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         en_r <= {NUM_IRQ{1'b0}};
         pend_r <= {NUM_IRQ{1'b0}};
         act_r <= {NUM_IRQ{1'b0}};
         for (n_st = 0; n_st < NUM_IRQ; n_st = n_st + 1)
            prio_r[n_st] <= `NESTED_VECTOR_IRQ_CTRL_PRIO_ZERO;
      end
      else
      begin
         en_r <= en_nxt;
         pend_r <= pend_nxt;
         act_r <= act_nxt;
         for (n_st = 0; n_st < NUM_IRQ; n_st = n_st + 1)
            if (prio_we[n_st])
               prio_r[n_st] <= i_wdata[(n_st % 4) * 8 +: 8] & PRIO_KEEP;
      end
   end

   // per-bank views of the addressed word, gathered before the select
   reg [31:0] en_word;
   reg [31:0] pd_word;
   reg [31:0] act_word;
   reg [31:0] prio_word;

   always @*
   begin
      en_word = `NESTED_VECTOR_IRQ_CTRL_WORD_ZERO;
      pd_word = `NESTED_VECTOR_IRQ_CTRL_WORD_ZERO;
      act_word = `NESTED_VECTOR_IRQ_CTRL_WORD_ZERO;
      prio_word = `NESTED_VECTOR_IRQ_CTRL_WORD_ZERO;
      for (n_rd = 0; n_rd < NUM_IRQ; n_rd = n_rd + 1)
      begin
         if (widx == n_rd / 32)
         begin
            en_word[n_rd % 32] = en_r[n_rd];
            pd_word[n_rd % 32] = pend_r[n_rd];
            act_word[n_rd % 32] = act_r[n_rd];
         end
         if (wofs[31:2] == n_rd / 4)
            prio_word[(n_rd % 4) * 8 +: 8] = prio_r[n_rd];
      end
   end

   // read mux; trigger register is write-only and reads zero
   always @*
   begin
      rdata_nxt = `NESTED_VECTOR_IRQ_CTRL_WORD_ZERO;
      err_nxt = refuse;
      if (a_sen || a_cen)
         rdata_nxt = en_word;
      if (a_spd || a_cpd)
         rdata_nxt = pd_word;
      if (a_act)
         rdata_nxt = act_word;
      if (a_pri)
         rdata_nxt = prio_word;
      // refused reads must not leak state to unprivileged code
      if (!acc || i_wr || refuse)
         rdata_nxt = `NESTED_VECTOR_IRQ_CTRL_WORD_ZERO;
   end

   always @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_rdata <= `NESTED_VECTOR_IRQ_CTRL_WORD_ZERO;
         o_bus_err <= 1'b0;
      end
      else
      begin
         o_rdata <= rdata_nxt;
         o_bus_err <= acc && err_nxt;
      end
   end

   // arbiter: strict less-than keeps the lowest number on ties
   reg [8:0] best_p;
   reg [7:0] best_n;
   always @*
   begin
      best_p = `NESTED_VECTOR_IRQ_CTRL_PRIO_IDLE;
      best_n = 8'h00;
      for (n_ar = 0; n_ar < NUM_IRQ; n_ar = n_ar + 1)
         if (pend_r[n_ar] && en_r[n_ar] && {1'b0, prio_r[n_ar]} < best_p)
         begin
            best_p = {1'b0, prio_r[n_ar]};
            best_n = n_ar[7:0];
         end
   end

   // a full linear scan costs depth but keeps the tie rule obvious
   wire req_nxt = !best_p[8];
   wire [7:0] grp_nxt = group_of(best_p[7:0], i_prigroup);

   always @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_irq_req <= 1'b0;
         o_irq_num <= 8'h00;
         o_irq_prio <= `NESTED_VECTOR_IRQ_CTRL_PRIO_ZERO;
         o_irq_group <= `NESTED_VECTOR_IRQ_CTRL_PRIO_ZERO;
      end
      else
      begin
         o_irq_req <= req_nxt;
         o_irq_num <= best_n;
         o_irq_prio <= best_p[7:0];
         o_irq_group <= grp_nxt;
      end
   end

endmodule // nested_vector_irq_ctrl_core

/* File: verif/nested_vector_irq_ctrl_chk.sv */
// nested_vector_irq_ctrl_chk.sv: port checks on nested_vector_irq_ctrl_core
// assumes a one-cycle bus with read data in the next cycle
`timescale 1ns/1ps
module nested_vector_irq_ctrl_chk #(
   parameter PRIO_BITS = 4
) (
   input wire i_clk,
   input wire i_rst_b,
   input wire i_sel,
   input wire i_wr,
   input wire i_priv,
   input wire [31:0] i_addr,
   input wire [31:0] i_wdata,
   input wire [3:0] i_be,
   input wire [31:0] o_rdata,
   input wire o_bus_err,
   input wire i_nmi,
   input wire o_nmi,
   input wire o_irq_req,
   input wire [7:0] o_irq_prio
);
   localparam [7:0] LOW = 8'hFF >> PRIO_BITS;
   wire wr = i_sel && i_wr && i_priv;
   wire rd = i_sel && !i_wr && i_priv;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   property p_err; i_sel && !i_priv && i_addr == 32'hE000E100 |=> o_bus_err; endproperty
   a_err: assert property (p_err) else $error("access not refused");
   property p_ok; i_sel && i_priv |=> !o_bus_err; endproperty
   a_ok: assert property (p_ok) else $error("spurious bus error");
   property p_map; rd && i_addr == 32'hE000E380 |=> o_rdata == 32'h0; endproperty
   a_map: assert property (p_map) else $error("hole reads nonzero");
   property p_rst; $rose(i_rst_b) |-> !o_irq_req && !o_bus_err && o_rdata == 32'h0; endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear");
   property p_nmi; o_nmi == $past(i_nmi, 2); endproperty
   a_nmi: assert property (p_nmi) else $error("nmi latency");
   property p_low; o_irq_req |-> (o_irq_prio & LOW) == 8'h00; endproperty
   a_low: assert property (p_low) else $error("low priority bits set");
   property p_prio; wr && i_addr == 32'hE000E400 && i_be == 4'hF ##1 !i_sel ##1
      rd && i_addr == 32'hE000E400 |=> o_rdata == ($past(i_wdata, 3) & {4{~LOW}}); endproperty
   a_prio: assert property (p_prio) else $error("priority readback");
   property p_set; wr && i_addr == 32'hE000E100 ##1 !i_sel ##1 rd && i_addr == 32'hE000E100
      |=> (o_rdata & $past(i_wdata, 3)) == $past(i_wdata, 3); endproperty
   a_set: assert property (p_set) else $error("enable not set");
   property p_clr; wr && i_addr == 32'hE000E180 ##1 !i_sel ##1 rd && i_addr == 32'hE000E180
      |=> (o_rdata & $past(i_wdata, 3)) == 32'h0; endproperty
   a_clr: assert property (p_clr) else $error("enable not cleared");
endmodule // nested_vector_irq_ctrl_chk
bind nested_vector_irq_ctrl_core nested_vector_irq_ctrl_chk #(.PRIO_BITS(PRIO_BITS)) nested_vector_irq_ctrl_chk_i (.i_clk, .i_rst_b, .i_sel, .i_wr,
   .i_priv, .i_addr, .i_wdata, .i_be, .o_rdata, .o_bus_err, .i_nmi, .o_nmi, .o_irq_req,
   .o_irq_prio);

/* File: verif/nested_vector_irq_ctrl_cpu_model.sv */
// nested_vector_irq_ctrl_cpu_model.sv: core side, enters the presented line and returns after a hold time
// assumes the controller samples entry and return strobes on i_clk
`timescale 1ns/1ps
module nested_vector_irq_ctrl_cpu_model #(
   parameter HOLD = 20
) (
   input wire i_clk,
   input wire i_take,
   input wire i_irq_req,
   input wire [7:0] i_irq_num,
   output reg o_entry = 1'b0,
   output reg [7:0] o_entry_num = 8'hFF,
   output reg o_return = 1'b0,
   output reg [7:0] o_return_num = 8'hFF
);
   reg [7:0] num_r = 8'h00;
   integer cnt = 0;
   always @(posedge i_clk)
   begin
      o_entry <= 1'b0;
      o_return <= 1'b0;
      // numbers toggle outside strobes so a stale number never looks valid
      o_entry_num <= ~o_entry_num;
      o_return_num <= ~o_return_num;
      if (cnt > 0)
         cnt <= cnt - 1;
      if (cnt == 0 && i_take && i_irq_req)
      begin
         o_entry <= 1'b1;
         o_entry_num <= i_irq_num;
         num_r <= i_irq_num;
         cnt <= HOLD;
      end
      if (cnt == 1)
      begin
         o_return <= 1'b1;
         o_return_num <= num_r;
      end
   end
endmodule // nested_vector_irq_ctrl_cpu_model

/* File: verif/nested_vector_irq_ctrl_core_tb_top.sv */
// nested_vector_irq_ctrl_core_tb_top.sv: self-checking bench for nested_vector_irq_ctrl_core against a bench model
// assumes the core model of nested_vector_irq_ctrl_cpu_model on the entry and return strobes
`timescale 1ns/1ps
module nested_vector_irq_ctrl_core_tb_top;
   reg i_clk = 1'b0, i_rst_b = 1'b0, i_sel = 1'b0, i_wr = 1'b0, i_priv = 1'b1, i_nmi = 1'b0;
   reg take = 1'b0, p = 1'b1;
   reg [31:0] i_addr = 32'h0, i_wdata = 32'h0, v, e, mask;
   reg [3:0] i_be = 4'hF;
   reg [39:0] i_irq = 40'h0;
   reg [2:0] i_prigroup = 3'h0;
   wire [31:0] o_rdata;
   wire [7:0] o_irq_num, o_irq_prio, o_irq_group, en_n, rt_n;
   wire o_bus_err, o_irq_req, o_nmi, en, rt;
   integer error_cnt = 0, checks_done = 0, i, k, best;
   integer pr[0:7];
   nested_vector_irq_ctrl_core #(.NUM_IRQ(40)) nested_vector_irq_ctrl_core_i (.i_clk, .i_rst_b, .i_sel, .i_wr, .i_priv, .i_addr,
      .i_wdata, .i_be, .o_rdata, .o_bus_err, .i_irq, .i_nmi, .i_prigroup, .i_entry(en),
      .i_entry_num(en_n), .i_return(rt), .i_return_num(rt_n), .o_irq_req, .o_irq_num,
      .o_irq_prio, .o_irq_group, .o_nmi);
   nested_vector_irq_ctrl_cpu_model nested_vector_irq_ctrl_cpu_model_i (.i_clk, .i_take(take), .i_irq_req(o_irq_req),
      .i_irq_num(o_irq_num), .o_entry(en), .o_entry_num(en_n), .o_return(rt),
      .o_return_num(rt_n));
   initial forever #50 i_clk = ~i_clk;
   task summarize;
   begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
   begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task acc(input w, input [31:0] a, input [31:0] d);
   begin
      @(posedge i_clk);
      i_sel <= 1'b1;
      i_wr <= w;
      i_priv <= p;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_sel <= 1'b0;
      #1;
   end
   endtask
   task rd(input [31:0] a, input [31:0] exp);
   begin
      acc(1'b0, a, 32'h0);
      chk(o_rdata, exp);
   end
   endtask
   task settle;
   begin
      repeat (3) @(posedge i_clk);
      #1;
   end
   endtask
   // strobes last one cycle, so poll every cycle under a bound
   task wt(input s);
   begin
      for (k = 0; k < 60 && (s ? !rt : !en); k = k + 1)
         @(posedge i_clk) #1;
      if (s ? !rt : !en)
      begin
         error_cnt = error_cnt + 1;
         summarize;
      end
   end
   endtask
   initial
   begin
      #1000000;
      error_cnt = error_cnt + 1;
      summarize;
   end
   initial
   begin
      i = $urandom(42362);
      repeat (8) @(posedge i_clk);
      i_rst_b <= 1'b1;
      for (i = 0; i < 8; i = i + 1)
         rd(32'hE000E100 + 32'h80 * i, 32'h0);
      rd(32'hE000EF00, 32'h0);
      p = 1'b0;
      acc(1'b1, 32'hE000E100, 32'hFFFFFFFF);
      chk(o_bus_err, 1'b1);
      p = 1'b1;
      rd(32'hE000E100, 32'h0);
      @(posedge i_clk) i_irq[5] <= 1'b1;
      settle;
      rd(32'hE000E200, 32'h20);
      chk(o_irq_req, 1'b0);
      acc(1'b1, 32'hE000E204, 32'h2);
      rd(32'hE000E284, 32'h2);
      acc(1'b1, 32'hE000E284, 32'h2);
      rd(32'hE000E204, 32'h0);
      acc(1'b1, 32'hE000E100, 32'h20);
      settle;
      chk({o_irq_req, o_irq_num}, {1'b1, 8'h05});
      take = 1'b1;
      wt(1'b0);
      take = 1'b0;
      settle;
      rd(32'hE000E300, 32'h20);
      acc(1'b1, 32'hE000E280, 32'h20);
      rd(32'hE000E300, 32'h20);
      wt(1'b1);
      settle;
      rd(32'hE000E200, 32'h20);
      rd(32'hE000E300, 32'h0);
      @(posedge i_clk) i_irq[5] <= 1'b0;
      settle;
      acc(1'b1, 32'hE000E180, 32'hFFFFFFFF);
      rd(32'hE000E180, 32'h0);
      acc(1'b1, 32'hE000E280, 32'hFFFFFFFF);
      for (i = 0; i < 6; i = i + 1)
      begin
         e = 32'h0;
         for (k = 7; k >= 0; k = k - 1)
         begin
            if (k % 4 == 3)
            begin
               v = $urandom;
               acc(1'b1, 32'hE000E3FD + k, v);
            end
            pr[k] = (v >> (8 * (k % 4))) & 32'hF0;
            e = e | (pr[k] << (8 * k));
         end
         rd(32'hE000E400, e);
         v = $urandom;
         @(posedge i_clk) {i_nmi, i_prigroup} <= v[14:11];
         mask = v[7:0] | (8'h01 << v[10:8]);
         acc(1'b1, 32'hE000E200, v[7:0]);
         acc(1'b1, 32'hE000EF00, v[10:8]);
         acc(1'b1, 32'hE000E100, v[23:16]);
         rd(32'hE000E100, v[23:16]);
         rd(32'hE000E280, mask);
         best = -1;
         for (k = 7; k >= 0; k = k - 1)
            if (v[16 + k] && mask[k] && (best < 0 || pr[k] <= pr[best]))
               best = k;
         settle;
         chk(o_irq_req, best >= 0);
         if (best >= 0)
         begin
            chk({o_irq_num, o_irq_prio}, {best[7:0], pr[best][7:0]});
            chk(o_irq_group, pr[best] & (32'hFF << (v[13:11] + 1)) & 32'hFF);
         end
         acc(1'b1, 32'hE000E180, 32'hFF);
         rd(32'hE000E180, 32'h0);
         acc(1'b1, 32'hE000E280, 32'hFF);
      end
      summarize;
   end
endmodule // nested_vector_irq_ctrl_core_tb_top
